// >>> hw/liu_rx_info_pkg.sv
// Constants for the receive information and interrupt mask register block
// Functional notes
// - Mask bit one enables matching status interrupt
// - Zero run of four or eight latches flag
// - Sixteen consecutive zeros latch long-run flag
// - Substitution codeword latches flag regardless of decoding
// - Carrier-loss clear criterion met latches flag
// - All-ones condition ending latches flag
// - Jitter FIFO within four bits latches flag
// - Unassigned information bits read zero, host ignores
// - Real-time receive level code in bits 7:4
// - Loop-up five seconds sets, loop-down five clears
// - Auto loopback disabled forces indication low
// - One-second tick from receive bits, clear-on-read
// - Clear: 32 ones/255 E1, 14/112 T1
// - Enabled status asserts interrupt until its read
package liu_rx_info_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h06;
  localparam logic [7:0] ADDR_INTERRUPT_MASK = 8'h07;
  localparam logic [7:0] ADDR_RECEIVE_EVENT_FLAGS = 8'h08;
  localparam logic [7:0] ADDR_RECEIVE_LEVEL_LOOP = 8'h09;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_ZERO_RUN = 7;
  localparam int BIT_LONG_ZERO_RUN = 6;
  localparam int BIT_SUBST_CODEWORD = 5;
  localparam int BIT_CARRIER_CLEARED = 4;
  localparam int BIT_ALL_ONES_CLEARED = 3;
  localparam int BIT_JITTER_LIMIT = 2;
  localparam int BIT_AUTO_LOOP = 1;
  localparam int BIT_ONE_HZ = 0;
  localparam logic [7:0] CHANGE_IRQ_BITS = 8'h38;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [4:0] ZERO_RUN_E1 = 5'h04;
  localparam logic [4:0] ZERO_RUN_T1 = 5'h08;
  localparam logic [4:0] ZERO_RUN_LONG = 5'h10;
  localparam logic [7:0] CL_WINDOW_E1 = 8'hff;
  localparam logic [5:0] CL_ONES_E1 = 6'h20;
  localparam logic [7:0] CL_WINDOW_T1 = 8'h70;
  localparam logic [5:0] CL_ONES_T1 = 6'h0e;
  localparam logic [7:0] JITTER_USABLE_LIMIT = 8'h80;
  localparam logic [7:0] JITTER_MARGIN = 8'h04;
  localparam logic [2:0] LOOP_HOLD_SECONDS = 3'h5;

  // ----------------------------------------------------------------
  // Loopback states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LOOP_IDLE = 2'b01,
    LOOP_ACTIVE = 2'b10
  } loop_state_type;

endpackage

// >>> hw/liu_rx_event_detect.sv
// Zero-run and carrier-loss clearing detector on the received bit stream
`timescale 1ns/10ps
module liu_rx_event_detect (
  input wire logic clk,
  input wire logic reset,
  input wire logic bit_en,
  input wire logic rx_one,
  input wire logic t1_mode_select,
  input wire logic carrier_loss,
  output logic zero_run_ev,
  output logic long_zero_run_ev,
  output logic carrier_clear_ev
);

  typedef struct packed {
    logic [4:0] zero_run;
    logic in_win;
    logic [7:0] bit_cnt;
    logic [5:0] ones_cnt;
    logic zero_ev;
    logic long_ev;
    logic cl_ev;
  } detect_state_type;

  detect_state_type q, n;
  logic [4:0] thr;
  logic [7:0] win;
  logic [5:0] need;
  logic [5:0] ones;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    thr = t1_mode_select ? liu_rx_info_pkg::ZERO_RUN_T1 : liu_rx_info_pkg::ZERO_RUN_E1;
    win = t1_mode_select ? liu_rx_info_pkg::CL_WINDOW_T1 : liu_rx_info_pkg::CL_WINDOW_E1;
    need = t1_mode_select ? liu_rx_info_pkg::CL_ONES_T1 : liu_rx_info_pkg::CL_ONES_E1;
    ones = 6'(q.ones_cnt + {5'h00, rx_one});
    n = q;
    n.zero_ev = 1'b0;
    n.long_ev = 1'b0;
    n.cl_ev = 1'b0;
    if (bit_en) begin
      if (rx_one) begin
        n.zero_run = 5'h00;
      end else if (q.zero_run != liu_rx_info_pkg::ZERO_RUN_LONG) begin
        n.zero_run = 5'(q.zero_run + 5'h01);
      end
      n.zero_ev = !rx_one && (5'(q.zero_run + 5'h01) == thr);
      n.long_ev = !rx_one && (5'(q.zero_run + 5'h01) == liu_rx_info_pkg::ZERO_RUN_LONG);
      if (!carrier_loss) begin
        n.in_win = 1'b0;
      end else if (!q.in_win) begin
        if (rx_one) begin
          n.in_win = 1'b1;
          n.bit_cnt = 8'h01;
          n.ones_cnt = 6'h01;
        end
      end else if (q.bit_cnt == win) begin
        n.in_win = 1'b0;
      end else if (ones >= need) begin
        n.cl_ev = 1'b1;
        n.in_win = 1'b0;
      end else begin
        n.bit_cnt = 8'(q.bit_cnt + 8'h01);
        n.ones_cnt = ones;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign zero_run_ev = q.zero_ev;
  assign long_zero_run_ev = q.long_ev;
  assign carrier_clear_ev = q.cl_ev;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_CLEAR_NEEDS_LOSS: assert property (q.cl_ev |-> $past(carrier_loss) && $past(bit_en))
    else $error("carrier clear event outside carrier loss");
  AST_LONG_RUN_COUNT: assert property (q.long_ev |-> $past(q.zero_run) == 5'h0f)
    else $error("long zero run event at wrong count");

endmodule // liu_rx_event_detect

// >>> hw/liu_rx_info_regs.sv
// Receive information registers, interrupt mask and interrupt output
`timescale 1ns/10ps
module liu_rx_info_regs #(
  parameter logic [21:0] SECOND_BITS_E1 = 22'h1f4000,
  parameter logic [21:0] SECOND_BITS_T1 = 22'h178f40
) (
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  output logic INT_N,
  output logic AUTO_REMOTE_LOOP,
  input wire logic RX_BIT_EN,
  input wire logic RX_ONE,
  input wire logic T1_MODE_SELECT,
  input wire logic CODEWORD_SEEN,
  input wire logic CARRIER_LOSS,
  input wire logic UNFRAMED_ALL_ONES,
  input wire logic [7:0] JITTER_FILL,
  input wire logic [3:0] RX_LEVEL,
  input wire logic LOOP_UP_DETECTED,
  input wire logic LOOP_DOWN_DETECTED,
  input wire logic AUTO_LOOPBACK_ENABLE,
  input wire logic [7:0] ALARM_STATUS
);

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] flags;
    logic one_hz;
    logic [21:0] bit_cnt;
    liu_rx_info_pkg::loop_state_type loop_st;
    logic [2:0] up_secs;
    logic [2:0] dn_secs;
    logic [7:0] pend;
    logic [7:0] status_prev;
    logic ones_prev;
    logic [7:0] rdata;
    logic int_n;
    logic auto_loop;
  } regs_state_type;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] target);
    addr_hit = (a == target);
  endfunction

  regs_state_type q, n;
  logic zero_run_ev;
  logic long_zero_run_ev;
  logic carrier_clear_ev;
  logic rd_flags;
  logic rd_level;
  logic rd_status;
  logic wr_mask;
  logic jitter_trip;
  logic tick;
  logic [21:0] second_len;
  logic [7:0] ev;
  logic [7:0] cause;

  // ----------------------------------------------------------------
  // Line event detection
  // ----------------------------------------------------------------
  liu_rx_event_detect liu_rx_event_detect_i (
    .clk(REF_CLK),
    .reset(RESET),
    .bit_en(RX_BIT_EN),
    .rx_one(RX_ONE),
    .t1_mode_select(T1_MODE_SELECT),
    .carrier_loss(CARRIER_LOSS),
    .zero_run_ev(zero_run_ev),
    .long_zero_run_ev(long_zero_run_ev),
    .carrier_clear_ev(carrier_clear_ev)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    rd_flags = RD_EN && addr_hit(ADDR, liu_rx_info_pkg::ADDR_RECEIVE_EVENT_FLAGS);
    rd_level = RD_EN && addr_hit(ADDR, liu_rx_info_pkg::ADDR_RECEIVE_LEVEL_LOOP);
    rd_status = RD_EN && addr_hit(ADDR, liu_rx_info_pkg::ADDR_ALARM_STATUS);
    wr_mask = WR_EN && addr_hit(ADDR, liu_rx_info_pkg::ADDR_INTERRUPT_MASK);
    jitter_trip = JITTER_FILL >=
                  8'(liu_rx_info_pkg::JITTER_USABLE_LIMIT - liu_rx_info_pkg::JITTER_MARGIN);
    second_len = T1_MODE_SELECT ? SECOND_BITS_T1 : SECOND_BITS_E1;
    tick = RX_BIT_EN && (q.bit_cnt == 22'(second_len - 22'h000001));
    ev = 8'h00;
    ev[liu_rx_info_pkg::BIT_ZERO_RUN] = zero_run_ev;
    ev[liu_rx_info_pkg::BIT_LONG_ZERO_RUN] = long_zero_run_ev;
    ev[liu_rx_info_pkg::BIT_SUBST_CODEWORD] = CODEWORD_SEEN;
    ev[liu_rx_info_pkg::BIT_CARRIER_CLEARED] = carrier_clear_ev;
    ev[liu_rx_info_pkg::BIT_ALL_ONES_CLEARED] = q.ones_prev && !UNFRAMED_ALL_ONES;
    ev[liu_rx_info_pkg::BIT_JITTER_LIMIT] = jitter_trip;
    cause = (ALARM_STATUS & ~q.status_prev) |
            ((ALARM_STATUS ^ q.status_prev) & liu_rx_info_pkg::CHANGE_IRQ_BITS);
    n = q;
    n.status_prev = ALARM_STATUS;
    n.ones_prev = UNFRAMED_ALL_ONES;
    if (wr_mask) begin
      n.mask = WDATA;
    end
    // ----------------------------------------------------------------
    // Latched flags, set wins over the read clear
    // ----------------------------------------------------------------
    n.flags = (rd_flags ? liu_rx_info_pkg::FLAGS_RESET : q.flags) | ev;
    n.one_hz = (rd_level ? 1'b0 : q.one_hz) | tick;
    n.pend = (rd_status ? 8'h00 : q.pend) | cause;
    n.int_n = ~|(n.pend & n.mask);
    if (RX_BIT_EN) begin
      n.bit_cnt = tick ? 22'h000000 : 22'(q.bit_cnt + 22'h000001);
    end
    // ----------------------------------------------------------------
    // Loopback second counters
    // ----------------------------------------------------------------
    if (!LOOP_UP_DETECTED || !AUTO_LOOPBACK_ENABLE) begin
      n.up_secs = 3'h0;
    end else if (tick && q.up_secs != liu_rx_info_pkg::LOOP_HOLD_SECONDS) begin
      n.up_secs = 3'(q.up_secs + 3'h1);
    end
    if (!LOOP_DOWN_DETECTED || !AUTO_LOOPBACK_ENABLE) begin
      n.dn_secs = 3'h0;
    end else if (tick && q.dn_secs != liu_rx_info_pkg::LOOP_HOLD_SECONDS) begin
      n.dn_secs = 3'(q.dn_secs + 3'h1);
    end
    case (q.loop_st)
      liu_rx_info_pkg::LOOP_IDLE: begin
        if (q.up_secs == liu_rx_info_pkg::LOOP_HOLD_SECONDS) begin
          n.loop_st = liu_rx_info_pkg::LOOP_ACTIVE;
        end
      end
      liu_rx_info_pkg::LOOP_ACTIVE: begin
        if (q.dn_secs == liu_rx_info_pkg::LOOP_HOLD_SECONDS) begin
          n.loop_st = liu_rx_info_pkg::LOOP_IDLE;
        end
      end
      default: begin
        n.loop_st = liu_rx_info_pkg::LOOP_IDLE;
      end
    endcase
    if (!AUTO_LOOPBACK_ENABLE) begin
      n.loop_st = liu_rx_info_pkg::LOOP_IDLE;
    end
    n.auto_loop = (n.loop_st == liu_rx_info_pkg::LOOP_ACTIVE);
    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    if (RD_EN) begin
      case (ADDR)
        liu_rx_info_pkg::ADDR_INTERRUPT_MASK: begin
          n.rdata = q.mask;
        end
        liu_rx_info_pkg::ADDR_RECEIVE_EVENT_FLAGS: begin
          n.rdata = {q.flags[7:2], 2'b00};
        end
        liu_rx_info_pkg::ADDR_RECEIVE_LEVEL_LOOP: begin
          n.rdata = {RX_LEVEL, 2'b00, q.auto_loop, q.one_hz};
        end
        default: begin
          n.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      q <= '0;
      q.mask <= liu_rx_info_pkg::MASK_RESET;
      q.flags <= liu_rx_info_pkg::FLAGS_RESET;
      q.loop_st <= liu_rx_info_pkg::LOOP_IDLE;
      q.int_n <= 1'b1;
    end else begin
      q <= n;
    end
  end

  assign RDATA = q.rdata;
  assign INT_N = q.int_n;
  assign AUTO_REMOTE_LOOP = q.auto_loop;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);

  AST_MASKED_RISE_INTERRUPTS: assert property (
    (|(ALARM_STATUS & ~q.status_prev & q.mask) && !wr_mask) |=> !INT_N)
    else $error("enabled status rise did not pull interrupt low");
  AST_MASKED_OFF_QUIET: assert property (
    (q.mask == 8'h00 && !wr_mask) |=> INT_N)
    else $error("interrupt asserted with all bits masked");
  AST_STATUS_READ_RELEASES: assert property (
    (rd_status && cause == 8'h00) |=> INT_N)
    else $error("interrupt held after status read");
  AST_ZERO_RUN_LATCH: assert property (zero_run_ev |=> q.flags[7])
    else $error("zero run flag not latched");
  AST_LONG_RUN_LATCH: assert property (long_zero_run_ev |=> q.flags[6])
    else $error("long zero run flag not latched");
  AST_CODEWORD_LATCH: assert property (CODEWORD_SEEN |=> q.flags[5])
    else $error("codeword flag not latched");
  AST_CARRIER_CLEAR_LATCH: assert property (carrier_clear_ev |=> q.flags[4])
    else $error("carrier clear flag not latched");
  AST_ONES_CLEAR_LATCH: assert property ($fell(UNFRAMED_ALL_ONES) |=> q.flags[3])
    else $error("all ones cleared flag not latched");
  AST_JITTER_LATCH: assert property (
    (JITTER_FILL >= 8'h7c) |=> q.flags[2] && q.flags[7:2] != 6'h00)
    else $error("jitter flag not latched");
  AST_READ_CLEARS_FLAGS: assert property ((rd_flags && ev == 8'h00) |=> q.flags == 8'h00)
    else $error("flags not cleared by read");
  AST_SET_BEATS_CLEAR: assert property ((rd_flags && zero_run_ev) |=> q.flags[7])
    else $error("event lost against read");
  AST_LEVEL_READBACK: assert property (
    rd_level |=> RDATA[7:4] == $past(RX_LEVEL) && RDATA[3:2] == 2'b00)
    else $error("receive level readback wrong");
  AST_LOOP_SET: assert property (
    (q.loop_st == liu_rx_info_pkg::LOOP_IDLE && q.up_secs == 3'h5 && AUTO_LOOPBACK_ENABLE)
    |=> AUTO_REMOTE_LOOP)
    else $error("auto loopback not set after hold");
  AST_LOOP_DISABLED_LOW: assert property (!AUTO_LOOPBACK_ENABLE |=> !AUTO_REMOTE_LOOP)
    else $error("auto loopback high while disabled");
  AST_ONE_HZ_LATCH: assert property (tick |=> q.one_hz && q.bit_cnt == 22'h000000)
    else $error("one second flag not set on boundary");

  // ----------------------------------------------------------------
  // Interrupt and readback checks
  // ----------------------------------------------------------------
  AST_MASK_WRITE: assert property (
    wr_mask |=> q.mask == $past(WDATA))
    else $error("mask write not taken");
  AST_MASK_STABLE: assert property (
    !wr_mask |=> $stable(q.mask))
    else $error("mask changed without a write");
  AST_CHANGE_FALL_INTERRUPTS: assert property (
    (|(~ALARM_STATUS & q.status_prev & liu_rx_info_pkg::CHANGE_IRQ_BITS & q.mask) && !wr_mask)
    |=> !INT_N)
    else $error("enabled change bit fall did not pull interrupt low");
  AST_PENDING_HOLDS: assert property (
    (!INT_N && !rd_status && !wr_mask) |=> !INT_N)
    else $error("interrupt released without status read");
  AST_FLAGS_READBACK: assert property (
    rd_flags |=> RDATA[7:2] == $past(q.flags[7:2]) && RDATA[1:0] == 2'b00)
    else $error("event flag readback wrong");
  AST_RDATA_STANDS: assert property (
    !RD_EN |=> $stable(RDATA))
    else $error("read data changed without a read");

  // ----------------------------------------------------------------
  // Flag hold, timer and loopback checks
  // ----------------------------------------------------------------
  AST_ZERO_FLAG_HOLDS: assert property (
    (q.flags[7] && !rd_flags) |=> q.flags[7])
    else $error("zero run flag lost without read");
  AST_ZERO_FLAG_QUIET: assert property (
    (!q.flags[7] && !zero_run_ev) |=> !q.flags[7])
    else $error("zero run flag set without event");
  AST_LONG_FLAG_HOLDS: assert property (
    (q.flags[6] && !rd_flags) |=> q.flags[6])
    else $error("long zero run flag lost without read");
  AST_CODEWORD_FLAG_HOLDS: assert property (
    (q.flags[5] && !rd_flags) |=> q.flags[5])
    else $error("codeword flag lost without read");
  AST_ONE_HZ_CLEAR: assert property (
    (rd_level && !tick) |=> !q.one_hz)
    else $error("one second flag not cleared by read");
  AST_ONE_HZ_HOLDS: assert property (
    (q.one_hz && !rd_level) |=> q.one_hz)
    else $error("one second flag lost without read");
  AST_ONE_HZ_NEEDS_BIT: assert property (
    (!q.one_hz && !RX_BIT_EN) |=> !q.one_hz)
    else $error("one second flag set without a bit");
  AST_UP_SECS_CLEAR: assert property (
    !LOOP_UP_DETECTED |=> q.up_secs == 3'h0)
    else $error("loop-up seconds kept without code");
  AST_DN_SECS_CLEAR: assert property (
    !LOOP_DOWN_DETECTED |=> q.dn_secs == 3'h0)
    else $error("loop-down seconds kept without code");
  AST_LOOP_NEEDS_HOLD: assert property (
    $rose(AUTO_REMOTE_LOOP) |-> $past(q.up_secs) == liu_rx_info_pkg::LOOP_HOLD_SECONDS)
    else $error("auto loopback set before hold time");
  AST_LOOP_HOLDS: assert property (
    (AUTO_REMOTE_LOOP && AUTO_LOOPBACK_ENABLE && q.dn_secs != liu_rx_info_pkg::LOOP_HOLD_SECONDS)
    |=> AUTO_REMOTE_LOOP)
    else $error("auto loopback dropped early");
  AST_LOOP_DROP: assert property (
    (AUTO_REMOTE_LOOP && q.dn_secs == liu_rx_info_pkg::LOOP_HOLD_SECONDS) |=> !AUTO_REMOTE_LOOP)
    else $error("auto loopback kept after loop-down hold");

  COV_INTERRUPT: cover property ($fell(INT_N));
  COV_LOOP_ACTIVE: cover property (q.loop_st == liu_rx_info_pkg::LOOP_ACTIVE);
  COV_READ_WITH_EVENT: cover property (rd_flags && |ev);
  COV_SECOND: cover property (tick);
  COV_LOOP_DROP: cover property ($fell(AUTO_REMOTE_LOOP));

endmodule // liu_rx_info_regs

// >>> bench/liu_rx_info_regs_tb.sv
// Testbench for the receive information and interrupt mask registers
`timescale 1ns/10ps
module liu_rx_info_regs_tb;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic int_n;
  logic auto_loop;
  logic bit_en = 1'b0;
  logic rx_one = 1'b0;
  logic t1 = 1'b0;
  logic cw = 1'b0;
  logic cl = 1'b0;
  logic ua1 = 1'b0;
  logic [7:0] jfill = 8'h00;
  logic [3:0] lvl = 4'h0;
  logic loop_up = 1'b0;
  logic loop_dn = 1'b0;
  logic alb_en = 1'b0;
  logic [7:0] alarm = 8'h00;
  logic [7:0] d;
  int err_count = 0;
  int tests_run = 0;

  always #12.5 ref_clk = ~ref_clk;

  liu_rx_info_regs #(.SECOND_BITS_E1(22'h000014), .SECOND_BITS_T1(22'h000010)) liu_rx_info_regs_i (
    .REF_CLK(ref_clk), .RESET(reset), .ADDR(addr), .WR_EN(wr_en), .RD_EN(rd_en),
    .WDATA(wdata), .RDATA(rdata), .INT_N(int_n), .AUTO_REMOTE_LOOP(auto_loop),
    .RX_BIT_EN(bit_en), .RX_ONE(rx_one), .T1_MODE_SELECT(t1), .CODEWORD_SEEN(cw),
    .CARRIER_LOSS(cl), .UNFRAMED_ALL_ONES(ua1), .JITTER_FILL(jfill), .RX_LEVEL(lvl),
    .LOOP_UP_DETECTED(loop_up), .LOOP_DOWN_DETECTED(loop_dn), .AUTO_LOOPBACK_ENABLE(alb_en),
    .ALARM_STATUS(alarm)
  );

  // ----------------------------------------------------------------
  // Compare, access and verdict tasks
  // ----------------------------------------------------------------
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t byte got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t bit got %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    @(posedge ref_clk);
    d = rdata;
  endtask

  task automatic bits(input logic v, input int n);
    repeat (n) begin
      @(posedge ref_clk);
      bit_en <= 1'b1;
      rx_one <= v;
      @(posedge ref_clk);
      bit_en <= 1'b0;
    end
    repeat (4) @(posedge ref_clk);
  endtask

  task automatic final_report;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd(8'h07); chk_byte(d, 8'h00);
    rd(8'h08); chk_byte(d, 8'h00);
    chk_bit(int_n, 1'b1);
    wr(8'h07, 8'ha5); rd(8'h07); chk_byte(d, 8'ha5);
    wr(8'h08, 8'hff); rd(8'h1f); chk_byte(d, 8'h00);
    rd(8'h08); chk_byte(d, 8'h00);
    wr(8'h07, 8'h00);
    for (int m = 0; m < 2; m++) begin
      t1 <= m[0];
      bits(1'b1, 1); bits(1'b0, 3 + 4 * m); bits(1'b1, 1);
      rd(8'h08); chk_byte(d, 8'h00);
      bits(1'b0, 4 + 4 * m); bits(1'b1, 1);
      rd(8'h08); chk_byte(d, 8'h80);
      rd(8'h08); chk_byte(d, 8'h00);
    end
    bits(1'b0, 15); bits(1'b1, 1);
    rd(8'h08); chk_byte(d, 8'h80);
    bits(1'b0, 16); bits(1'b1, 1);
    rd(8'h08); chk_byte(d, 8'hc0);
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      t1 <= (m == 0);
      cw <= 1'b1;
      @(posedge ref_clk);
      cw <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd(8'h08); chk_byte(d, 8'h20);
      rd(8'h08); chk_byte(d, 8'h00);
    end
    @(posedge ref_clk);
    ua1 <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h08); chk_byte(d, 8'h00);
    @(posedge ref_clk);
    ua1 <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(8'h08); chk_byte(d, 8'h08);
    rd(8'h08); chk_byte(d, 8'h00);
    @(posedge ref_clk);
    jfill <= 8'h7b;
    repeat (3) @(posedge ref_clk);
    rd(8'h08); chk_byte(d, 8'h00);
    @(posedge ref_clk);
    jfill <= 8'h7c;
    repeat (3) @(posedge ref_clk);
    rd(8'h08); chk_byte(d, 8'h04);
    @(posedge ref_clk);
    jfill <= 8'h00;
    rd(8'h08);
    rd(8'h08); chk_byte(d, 8'h00);
    @(posedge ref_clk);
    cl <= 1'b1;
    bits(1'b1, 31); rd(8'h08); chk_byte(d, 8'h00);
    bits(1'b1, 1); rd(8'h08); chk_byte(d, 8'h10);
    t1 <= 1'b1;
    bits(1'b1, 13); rd(8'h08); chk_byte(d, 8'h00);
    bits(1'b1, 1); rd(8'h08); chk_byte(d, 8'h10);
    bits(1'b1, 1); bits(1'b0, 99); bits(1'b1, 13);
    rd(8'h08); chk_byte(d, 8'hc0);
    cl <= 1'b0;
    t1 <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk);
      lvl <= i[3:0];
      rd(8'h09); chk_byte(d & 8'hfc, {i[3:0], 4'h0});
    end
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    bits(1'b1, 19); rd(8'h09); chk_byte(d & 8'h01, 8'h00);
    bits(1'b1, 1); rd(8'h09); chk_byte(d & 8'h01, 8'h01);
    rd(8'h09); chk_byte(d & 8'h01, 8'h00);
    t1 <= 1'b1;
    bits(1'b1, 15); rd(8'h09); chk_byte(d & 8'h01, 8'h00);
    bits(1'b1, 1); rd(8'h09); chk_byte(d & 8'h01, 8'h01);
    t1 <= 1'b0;
    alb_en <= 1'b1;
    loop_up <= 1'b1;
    bits(1'b1, 80); chk_bit(auto_loop, 1'b0);
    bits(1'b1, 20); chk_bit(auto_loop, 1'b1);
    rd(8'h09); chk_byte(d & 8'h02, 8'h02);
    loop_up <= 1'b0;
    loop_dn <= 1'b1;
    bits(1'b1, 80); chk_bit(auto_loop, 1'b1);
    bits(1'b1, 20); chk_bit(auto_loop, 1'b0);
    loop_dn <= 1'b0;
    loop_up <= 1'b1;
    bits(1'b1, 100); chk_bit(auto_loop, 1'b1);
    alb_en <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk_bit(auto_loop, 1'b0);
    rd(8'h09); chk_byte(d & 8'h02, 8'h00);
    bits(1'b1, 100); chk_bit(auto_loop, 1'b0);
    loop_up <= 1'b0;
    @(posedge ref_clk);
    alarm <= 8'h01;
    repeat (4) @(posedge ref_clk);
    chk_bit(int_n, 1'b1);
    wr(8'h07, 8'h01);
    repeat (2) @(posedge ref_clk);
    chk_bit(int_n, 1'b0);
    rd(8'h06); chk_bit(int_n, 1'b1);
    alarm <= 8'h00;
    for (int i = 0; i < 8; i++) begin
      wr(8'h07, 8'h01 << i);
      @(posedge ref_clk);
      alarm <= 8'h01 << i;
      repeat (3) @(posedge ref_clk);
      chk_bit(int_n, 1'b0);
      rd(8'h06); chk_bit(int_n, 1'b1);
      @(posedge ref_clk);
      alarm <= 8'h00;
      repeat (3) @(posedge ref_clk);
      chk_bit(int_n, (i < 3 || i > 5));
      rd(8'h06);
    end
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= 8'h08;
    cw <= 1'b1;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    cw <= 1'b0;
    repeat (3) @(posedge ref_clk);
    rd(8'h08); chk_byte(d, 8'h20);
    rd(8'h08); chk_byte(d, 8'h00);
    final_report;
  end
endmodule // liu_rx_info_regs_tb
